/* pwmh_top.sv */
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module pwmh_top
    import pwmh_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        fault_i,
    output logic             pwm_a_o,
    output logic             pwm_b_o,
    output logic             irq_o
);

    // fault pin synchroniser: three stages, change accepted when 2 and 3 agree
    logic [2:0] fsync_ff;
    logic       fault_ff;
    logic       nxt_fault;

    assign nxt_fault = (fsync_ff[1] == fsync_ff[2]) ? fsync_ff[2] : fault_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fsync_ff <= 3'h0;
            fault_ff <= 1'b0;
        end
        else
        begin
            fsync_ff <= {fsync_ff[1:0], fault_i};
            fault_ff <= nxt_fault;
        end
    end

    // register file
    pwmh_cfg_t              cfg_ff;
    logic [PWMH_CNT_W-1:0]  period_ff;
    logic [PWMH_CNT_W-1:0]  duty_ff;
    logic [PWMH_DEAD_W-1:0] dead_ff;
    logic [PWMH_ST_W-1:0]   stat_ff;
    logic [PWMH_ST_W-1:0]   mask_ff;
    logic [PWMH_ST_W-1:0]   nxt_stat;

    wire acc     = psel_i && penable_i;
    wire wr      = acc && pwrite_i;
    wire sel_ctl = (paddr_i == PWMH_OFF_CTRL);
    wire sel_per = (paddr_i == PWMH_OFF_PERIOD);
    wire sel_dut = (paddr_i == PWMH_OFF_DUTY);
    wire sel_ded = (paddr_i == PWMH_OFF_DEAD);
    wire sel_sta = (paddr_i == PWMH_OFF_STAT);
    wire sel_msk = (paddr_i == PWMH_OFF_MASK);
    wire sel_lvl = (paddr_i == PWMH_OFF_LEVEL);
    wire mapped  = sel_ctl | sel_per | sel_dut | sel_ded | sel_sta | sel_msk | sel_lvl;

    assign pready_o  = 1'b1;
    assign pslverr_o = acc && !mapped;

    // status events from the timebase and the shutdown state machine
    logic ev_shut;
    logic ev_period;
    logic ev_resume;

    wire [PWMH_ST_W-1:0] ev_vec = {ev_resume, ev_period, ev_shut};
    wire [PWMH_ST_W-1:0] w1c    = (wr && sel_sta) ? pwdata_i[PWMH_ST_W-1:0] : '0;

    // set wins over a simultaneous clear
    assign nxt_stat = (stat_ff & ~w1c) | ev_vec;
    assign irq_o    = |(stat_ff & mask_ff);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_ff    <= pwmh_cfg_t'(PWMH_CTRL_RST);
            period_ff <= PWMH_PERIOD_RST;
            duty_ff   <= PWMH_DUTY_RST;
            dead_ff   <= PWMH_DEAD_RST;
            mask_ff   <= PWMH_ST_RST;
            stat_ff   <= PWMH_ST_RST;
        end
        else
        begin
            stat_ff <= nxt_stat;
            if (wr && sel_ctl)
                cfg_ff <= pwmh_cfg_t'({pwdata_i[PWMH_CTRL_EN_BIT],
                                       pwdata_i[PWMH_CTRL_ASD_EN_BIT],
                                       pwdata_i[PWMH_CTRL_RESTART_BIT],
                                       pwdata_i[PWMH_CTRL_HALF_BIT],
                                       pwdata_i[PWMH_CTRL_POLA_BIT],
                                       pwdata_i[PWMH_CTRL_POLB_BIT]});
            if (wr && sel_per)
                period_ff <= pwdata_i[PWMH_CNT_W-1:0];
            if (wr && sel_dut)
                duty_ff <= pwdata_i[PWMH_CNT_W-1:0];
            if (wr && sel_ded)
                dead_ff <= pwdata_i[PWMH_DEAD_W-1:0];
            if (wr && sel_msk)
                mask_ff <= pwdata_i[PWMH_ST_W-1:0];
        end
    end

    // timebase: counts 0..period, a new period starts on wrap
    logic [PWMH_CNT_W-1:0] cnt_ff;
    logic [PWMH_CNT_W-1:0] nxt_cnt;
    logic [PWMH_CNT_W-1:0] per_lat_ff;
    logic [PWMH_CNT_W-1:0] duty_lat_ff;

    // period and duty take effect at the boundary, avoiding runt pulses
    wire per_end  = (cnt_ff >= per_lat_ff);
    wire per_strt = cfg_ff.enable && per_end;
    assign nxt_cnt = (!cfg_ff.enable || per_end) ? '0 : cnt_ff + 16'h0001;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_ff      <= '0;
            per_lat_ff  <= PWMH_PERIOD_RST;
            duty_lat_ff <= PWMH_DUTY_RST;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            if (per_strt || !cfg_ff.enable)
            begin
                per_lat_ff  <= period_ff;
                duty_lat_ff <= duty_ff;
            end
        end
    end

    // shutdown state machine
    pwmh_state_t st_ff;
    pwmh_state_t nxt_st;

    wire trip      = cfg_ff.asd_en && fault_ff;
    wire flag_gone = !stat_ff[PWMH_ST_SHUT_BIT];
    // without auto-restart the fault must end and software must clear the flag
    wire may_leave = !fault_ff && (cfg_ff.restart || flag_gone);

    always_comb
    begin
        nxt_st = st_ff;
        unique case (st_ff)
            PWMH_RUN:
                if (trip)
                    nxt_st = PWMH_SHUT;
            PWMH_SHUT:
                if (may_leave)
                    nxt_st = PWMH_WAIT_PER;
            PWMH_WAIT_PER:
                if (trip)
                    nxt_st = PWMH_SHUT;
                else if (per_end)
                    nxt_st = PWMH_RUN;
            default:
                nxt_st = PWMH_SHUT;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_ff <= PWMH_RUN;
        else
            st_ff <= nxt_st;
    end

    assign ev_shut   = (st_ff == PWMH_RUN) && trip;
    assign ev_period = per_strt;
    assign ev_resume = (st_ff == PWMH_WAIT_PER) && per_end && !trip;

    // raw drive: on for duty counts of each period, cut by shutdown
    wire running = cfg_ff.enable && (st_ff == PWMH_RUN) && !trip;
    wire on_ph   = (cnt_ff < duty_lat_ff);
    // half-bridge: b takes the remainder of the period, a's complement
    wire raw_a   = running && on_ph;
    wire raw_b   = running && cfg_ff.half && !on_ph;

    logic act_a;
    logic act_b;

    // dead time shortens both pulses by dead counts in half-bridge mode
    pwmh_dead u_dead_a
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .raw_i (raw_a),
        .dead_i(cfg_ff.half ? dead_ff : '0),
        .act_o (act_a)
    );

    pwmh_dead u_dead_b
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .raw_i (raw_b),
        .dead_i(dead_ff),
        .act_o (act_b)
    );

    // pol bit set means active low; inactive level held while shut
    pwmh_pair_t out_ff;
    pwmh_pair_t nxt_out;
    wire        live = (st_ff == PWMH_RUN) && !trip;

    assign nxt_out.a = (act_a && live) ^ cfg_ff.pol_a;
    assign nxt_out.b = (act_b && live) ^ cfg_ff.pol_b;
    assign pwm_a_o   = out_ff.a;
    assign pwm_b_o   = out_ff.b;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            out_ff <= '0;
        else
            out_ff <= nxt_out;
    end

    // read mux
    wire [31:0] rd_ctl = {26'h0, cfg_ff.pol_b, cfg_ff.pol_a, cfg_ff.half,
                          cfg_ff.restart, cfg_ff.asd_en, cfg_ff.enable};
    wire [31:0] rd_lvl = {28'h0, st_ff, fault_ff, 1'b0} >> 1;
    wire [31:0] rd_mux = sel_ctl ? rd_ctl :
                         sel_per ? {16'h0, period_ff} :
                         sel_dut ? {16'h0, duty_ff} :
                         sel_ded ? {25'h0, dead_ff} :
                         sel_sta ? {29'h0, stat_ff} :
                         sel_msk ? {29'h0, mask_ff} :
                         sel_lvl ? rd_lvl : 32'h0;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            prdata_o <= 32'h0;
        else if (psel_i && !penable_i && !pwrite_i)
            prdata_o <= rd_mux;
    end

endmodule // pwmh_top
`default_nettype wire

/* pwmh_pkg.sv */
package pwmh_pkg;

    // register byte offsets
    localparam logic [11:0] PWMH_OFF_CTRL   = 12'h000;
    localparam logic [11:0] PWMH_OFF_PERIOD = 12'h004;
    localparam logic [11:0] PWMH_OFF_DUTY   = 12'h008;
    localparam logic [11:0] PWMH_OFF_DEAD   = 12'h00C;
    localparam logic [11:0] PWMH_OFF_STAT   = 12'h010;
    localparam logic [11:0] PWMH_OFF_MASK   = 12'h014;
    localparam logic [11:0] PWMH_OFF_LEVEL  = 12'h018;

    // control field positions
    localparam int PWMH_CTRL_EN_BIT      = 0;
    localparam int PWMH_CTRL_ASD_EN_BIT  = 1;
    localparam int PWMH_CTRL_RESTART_BIT = 2;
    localparam int PWMH_CTRL_HALF_BIT    = 3;
    localparam int PWMH_CTRL_POLA_BIT    = 4;
    localparam int PWMH_CTRL_POLB_BIT    = 5;

    // status and mask field positions
    localparam int PWMH_ST_SHUT_BIT   = 0;
    localparam int PWMH_ST_PERIOD_BIT = 1;
    localparam int PWMH_ST_RESUME_BIT = 2;

    localparam int PWMH_CNT_W  = 16;
    localparam int PWMH_DEAD_W = 7;
    localparam int PWMH_ST_W   = 3;

    // reset values
    localparam logic [5:0]             PWMH_CTRL_RST   = 6'h00;
    localparam logic [PWMH_CNT_W-1:0]  PWMH_PERIOD_RST = 16'h00FF;
    localparam logic [PWMH_CNT_W-1:0]  PWMH_DUTY_RST   = 16'h0000;
    localparam logic [PWMH_DEAD_W-1:0] PWMH_DEAD_RST   = 7'h00;
    localparam logic [PWMH_ST_W-1:0]   PWMH_ST_RST     = 3'h0;

    typedef struct packed {
        logic enable;
        logic asd_en;
        logic restart;
        logic half;
        logic pol_a;
        logic pol_b;
    } pwmh_cfg_t;

    typedef struct packed {
        logic a;
        logic b;
    } pwmh_pair_t;

    typedef enum logic [1:0] {
        PWMH_RUN      = 2'b00,
        PWMH_SHUT     = 2'b01,
        PWMH_WAIT_PER = 2'b10
    } pwmh_state_t;

endpackage : pwmh_pkg

/* pwmh_dead.sv */
`timescale 1ns/100ps
`default_nettype none
// delays the rising edge of a raw drive level by a programmed count
module pwmh_dead
    import pwmh_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   raw_i,
    input  wire logic [PWMH_DEAD_W-1:0] dead_i,
    output logic                        act_o
);

    logic [PWMH_DEAD_W-1:0] cnt_ff;
    logic [PWMH_DEAD_W-1:0] nxt_cnt;
    logic                   act_ff;
    logic                   nxt_act;
    wire                    cnt_done = (cnt_ff >= dead_i);

    // falling edge is immediate so shutdown and duty end are never delayed
    assign nxt_cnt = !raw_i ? '0 : (cnt_done ? cnt_ff : cnt_ff + 7'h01);
    assign nxt_act = raw_i && (cnt_done || (dead_i == '0));
    assign act_o   = act_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_ff <= '0;
            act_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            act_ff <= nxt_act;
        end
    end

endmodule // pwmh_dead
`default_nettype wire

/* pwmh_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module pwmh_assertions
    import pwmh_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [31:0] prdata_o,
    input  wire logic        pready_o,
    input  wire logic        pslverr_o,
    input  wire logic        fault_i,
    input  wire logic        pwm_a_o,
    input  wire logic        pwm_b_o,
    input  wire logic        irq_o
);
    logic [5:0] ctrl_ff;
    wire        acc    = psel_i && penable_i;
    wire        mapped = paddr_i <= PWMH_OFF_LEVEL && paddr_i[1:0] == 2'h0;
    wire        armed  = ctrl_ff[PWMH_CTRL_EN_BIT] && ctrl_ff[PWMH_CTRL_ASD_EN_BIT];

    // shadow of the control word, the only way to know modes from the pins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_ff <= PWMH_CTRL_RST;
        else if (acc && pwrite_i && paddr_i == PWMH_OFF_CTRL)
            ctrl_ff <= pwdata_i[5:0];
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ready_high: assert property (pready_o)
        else $error("pready low");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr_o)
        else $error("no error on unmapped access");
    a_err_cause: assert property (pslverr_o |-> acc && !mapped)
        else $error("error without cause");
    a_err_read_zero: assert property (acc && !pwrite_i && !mapped |-> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> !pwm_a_o && !pwm_b_o && !irq_o && prdata_o == 32'h0)
        else $error("outputs active after reset");
    a_cut_fast: assert property (
        armed && $rose(fault_i) |-> ##[1:8] pwm_a_o == ctrl_ff[PWMH_CTRL_POLA_BIT])
        else $error("pulse not cut by fault");
    a_shut_idle: assert property (
        (armed && fault_i && $stable(ctrl_ff))[*8] |->
        pwm_a_o == ctrl_ff[PWMH_CTRL_POLA_BIT] && pwm_b_o == ctrl_ff[PWMH_CTRL_POLB_BIT])
        else $error("output active in shutdown");
    a_dead_gap: assert property (
        ctrl_ff[PWMH_CTRL_HALF_BIT] && ctrl_ff[5:4] == 2'h0 |-> !(pwm_a_o && pwm_b_o))
        else $error("both outputs active");

    c_shut: cover property (armed && fault_i && irq_o);
    c_half: cover property (ctrl_ff[PWMH_CTRL_HALF_BIT] && $rose(pwm_b_o));
    c_err: cover property (pslverr_o);
endmodule // pwmh_assertions
`default_nettype wire

/* pwmh_fault_src.sv */
`timescale 1ns/100ps
`default_nettype none
// comparator stand-in: holds the fault level for a set number of clocks
module pwmh_fault_src
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       trip_i,
    input  wire logic [7:0] len_i,
    output logic            fault_o
);
    logic [7:0] left_ff;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            left_ff <= 8'h00;
        else if (trip_i)
            left_ff <= len_i;
        else if (left_ff != 8'h00)
            left_ff <= left_ff - 8'h01;
    end
    assign fault_o = (left_ff != 8'h00);
endmodule // pwmh_fault_src
`default_nettype wire

/* pwmh_top_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module pwmh_top_tb_top
    import pwmh_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, trip = 1'b0;
    logic        pready, perr, err, fault, pa, pb, irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0]  flen = 8'h00;
    int          fail_count = 0, comparisons = 0, cyc = 0, ca, cb;

    pwmh_top dut_u (.clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(perr), .fault_i(fault), .pwm_a_o(pa),
        .pwm_b_o(pb), .irq_o(irq));
    pwmh_fault_src src_u (.clk_i(clk), .rst_i(rst), .trip_i(trip), .len_i(flen),
        .fault_o(fault));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    // extra edge at the end keeps back-to-back calls from re-driving psel in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic cnt(input int s, input int n, input logic la, input logic lb);
        ca = 0;
        cb = 0;
        repeat (s)
            @(posedge clk);
        repeat (n)
        begin
            @(posedge clk);
            ca += int'(pa === la);
            cb += int'(pb === lb);
        end
    endtask

    // waits for a fresh rising edge of output a, bounded
    task automatic wait_a();
        int k = 0;
        while (pa === 1'b1 && k < 60)
        begin
            @(posedge clk);
            k++;
        end
        while (pa !== 1'b1 && k < 120)
        begin
            @(posedge clk);
            k++;
        end
    endtask

    task automatic trip_fault(input logic [7:0] len);
        trip <= 1'b1;
        flen <= len;
        @(posedge clk);
        trip <= 1'b0;
    endtask

    task automatic t_regs();
        apb(1'b0, PWMH_OFF_PERIOD, 32'h0);
        chk("period reset", 32'hFF, rd);
        apb(1'b0, PWMH_OFF_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, 12'h01C, 32'h0);
        chk("unmapped read", 32'h1, {rd[30:0], err});
    endtask

    task automatic t_single();
        apb(1'b1, PWMH_OFF_PERIOD, 32'h9);
        apb(1'b1, PWMH_OFF_DUTY, 32'h4);
        apb(1'b1, PWMH_OFF_CTRL, 32'h1);
        cnt(20, 10, 1'b1, 1'b1);
        chk("on time", 32'h4, ca);
        apb(1'b1, PWMH_OFF_DUTY, 32'h6);
        cnt(20, 10, 1'b1, 1'b1);
        chk("new on time", 32'h6, ca);
        apb(1'b1, PWMH_OFF_PERIOD, 32'h13);
        cnt(40, 40, 1'b1, 1'b1);
        chk("new period", 32'hC, ca);
    endtask

    task automatic t_half();
        apb(1'b1, PWMH_OFF_CTRL, 32'h0);
        apb(1'b1, PWMH_OFF_DUTY, 32'hA);
        for (int d = 0; d < 6; d += 3)
        begin
            apb(1'b1, PWMH_OFF_DEAD, d);
            apb(1'b1, PWMH_OFF_CTRL, 32'h9);
            cnt(40, 20, 1'b1, 1'b1);
            chk("a width", 10 - d, ca);
            chk("b width", 10 - d, cb);
        end
        apb(1'b1, PWMH_OFF_CTRL, 32'h39);
        cnt(40, 20, 1'b0, 1'b0);
        chk("a low width", 32'h7, ca);
        chk("b low width", 32'h7, cb);
        apb(1'b1, PWMH_OFF_CTRL, 32'h0);
    endtask

    task automatic t_shut();
        apb(1'b1, PWMH_OFF_DEAD, 32'h0);
        apb(1'b1, PWMH_OFF_MASK, 32'h1);
        apb(1'b1, PWMH_OFF_CTRL, 32'h3);
        wait_a();
        trip_fault(8'h3C);
        cnt(0, 9, 1'b1, 1'b1);
        chk("cut pulse", 32'h1, ca < 7);
        cnt(0, 40, 1'b1, 1'b1);
        chk("held off", 32'h0, ca);
        chk("irq raised", 32'h1, irq);
        cnt(0, 40, 1'b1, 1'b1);
        chk("no self restart", 32'h0, ca);
        apb(1'b1, PWMH_OFF_STAT, 32'h1);
        chk("irq cleared", 32'h0, irq);
        wait_a();
        cnt(0, 20, 1'b1, 1'b1);
        chk("first pulse", 32'hA, ca);
    endtask

    task automatic t_restart();
        apb(1'b1, PWMH_OFF_STAT, 32'h7);
        apb(1'b1, PWMH_OFF_MASK, 32'h0);
        apb(1'b1, PWMH_OFF_CTRL, 32'h7);
        wait_a();
        trip_fault(8'h1E);
        cnt(8, 20, 1'b1, 1'b1);
        chk("held off", 32'h0, ca);
        apb(1'b0, PWMH_OFF_STAT, 32'h0);
        chk("masked irq", 32'h0, irq);
        chk("shut flag", 32'h1, rd[PWMH_ST_SHUT_BIT]);
        wait_a();
        cnt(0, 20, 1'b1, 1'b1);
        chk("auto restart", 32'hA, ca);
        apb(1'b0, PWMH_OFF_STAT, 32'h0);
        chk("resume flag", 32'h1, rd[PWMH_ST_RESUME_BIT]);
    endtask

    initial
    begin
        repeat (16)
            @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_single();
        t_half();
        t_shut();
        t_restart();
        wrap_up();
    end
endmodule // pwmh_top_tb_top

bind pwmh_top pwmh_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .fault_i(fault_i),
    .pwm_a_o(pwm_a_o), .pwm_b_o(pwm_b_o), .irq_o(irq_o));
`default_nettype wire
